// ---- mcl_defines.svh ----
/*
  Constants of the client loopback and management bridge.
  Assumes a single 100 MHz system clock drives the MAC client, management and PHY sides.
*/
`ifndef MCL_DEFINES_SVH
`define MCL_DEFINES_SVH
// ----------------------------------------------------------------------------
// Loopback FIFO geometry.
// ----------------------------------------------------------------------------
`define MCL_FIFO_AW    6
`define MCL_FIFO_DEPTH 7'h40
// ----------------------------------------------------------------------------
// AXI4-Lite response codes.
// ----------------------------------------------------------------------------
`define MCL_RESP_OKAY   2'h0
`define MCL_RESP_SLVERR 2'h2
`endif

// ---- mcl_pkg.sv ----
/*
  Types shared by the loopback wrapper.
  Assumes mcl_defines.svh is on the include path.
*/
`include "mcl_defines.svh"
package mcl_pkg;
  // One client stream beat, byte 0 in bits 7:0.
  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  keep;
    logic        last;
  } mcl_beat_t;
  // One XGMII-style word with its control lanes.
  typedef struct packed {
    logic [63:0] d;
    logic [7:0]  c;
  } mcl_xgmii_t;
  // Management bridge sequence.
  typedef enum logic [2:0] {
    BR_IDLE, BR_WRITE, BR_READ, BR_BRESP, BR_RRESP
  } mcl_br_state_t;
endpackage : mcl_pkg

// ---- mcl_top.sv ----
/*
  Client loopback with address swap, management bridge and PHY-side registers.
  Assumes the MAC client, management port and PHY wrapper all run on clk_sys_in.
*/
`timescale 1ns/1ps
`include "mcl_defines.svh"
module mcl_top (
  input  wire logic        clk_sys_in,              // System clock, 100 MHz.
  input  wire logic        nrst_in,                 // Asynchronous reset, active low.
  input  wire logic [63:0] rx_tdata_in,             // Received frame data from the MAC.
  input  wire logic [7:0]  rx_tkeep_in,             // Received byte valids.
  input  wire logic        rx_tvalid_in,            // Received beat valid.
  input  wire logic        rx_tlast_in,             // Received last beat.
  input  wire logic        rx_tuser_in,             // High on last beat when frame is good.
  output logic      [63:0] tx_tdata_out,            // Looped frame data to the MAC.
  output logic      [7:0]  tx_tkeep_out,            // Looped byte valids.
  output logic             tx_tvalid_out,           // Looped beat valid.
  output logic             tx_tlast_out,            // Looped last beat.
  input  wire logic        tx_tready_in,            // MAC accepts the beat.
  input  wire logic [31:0] s_axi_awaddr_in,         // AXI4-Lite write address.
  input  wire logic        s_axi_awvalid_in,        // Write address valid.
  output logic             s_axi_awready_out,       // Write address taken.
  input  wire logic [31:0] s_axi_wdata_in,          // Write data.
  input  wire logic        s_axi_wvalid_in,         // Write data valid.
  output logic             s_axi_wready_out,        // Write data taken.
  output logic      [1:0]  s_axi_bresp_out,         // Write response.
  output logic             s_axi_bvalid_out,        // Write response valid.
  input  wire logic        s_axi_bready_in,         // Write response taken.
  input  wire logic [31:0] s_axi_araddr_in,         // Read address.
  input  wire logic        s_axi_arvalid_in,        // Read address valid.
  output logic             s_axi_arready_out,       // Read address taken.
  output logic      [31:0] s_axi_rdata_out,         // Read data.
  output logic      [1:0]  s_axi_rresp_out,         // Read response.
  output logic             s_axi_rvalid_out,        // Read response valid.
  input  wire logic        s_axi_rready_in,         // Read response taken.
  output logic             mgmt_select_out,         // Register port select.
  output logic             mgmt_read_not_write_out, // High for read, low for write.
  output logic      [31:0] mgmt_reg_address_out,    // Register address.
  output logic      [31:0] mgmt_write_word_out,     // Word written to the MAC.
  input  wire logic [31:0] mgmt_read_word_in,       // Word read from the MAC.
  input  wire logic        mgmt_read_ack_in,        // Read acknowledge.
  input  wire logic        mgmt_write_ack_in,       // Write acknowledge.
  input  wire logic        mgmt_access_error_in,    // Invalid access, with acknowledge.
  input  wire logic        phy_ddr_mode_in,         // High selects the DDR receive path.
  input  wire logic [63:0] mac_txd_in,              // MAC transmit data.
  input  wire logic [7:0]  mac_txc_in,              // MAC transmit control.
  output logic      [63:0] mac_rxd_out,             // Receive data to the MAC.
  output logic      [7:0]  mac_rxc_out,             // Receive control to the MAC.
  output logic      [63:0] sdr_txd_out,             // SDR transmit data to the PHY.
  output logic      [7:0]  sdr_txc_out,             // SDR transmit control to the PHY.
  input  wire logic [63:0] sdr_rxd_in,              // SDR receive data from the PHY.
  input  wire logic [7:0]  sdr_rxc_in,              // SDR receive control from the PHY.
  output logic      [35:0] ddr_tx_rise_out,         // DDR lanes for the rising edge.
  output logic      [35:0] ddr_tx_fall_out,         // DDR lanes for the falling edge.
  input  wire logic [35:0] ddr_rx_in                // DDR receive lanes, {ctl, data}.
);
  // ----------------------------------------------------------------------------
  // Reset release.
  // ----------------------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n;

  // Two flip-flops release the reset on the clock.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in) {rst_n, rst_s1_r} <= 2'h0;
    else          {rst_n, rst_s1_r} <= {rst_s1_r, 1'b1};
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n);

  localparam int AW = `MCL_FIFO_AW;

  // Gray code helpers.
  function automatic logic [AW:0] b2g(input logic [AW:0] b);
    b2g = b ^ (b >> 1);
  endfunction : b2g
  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    for (int i = AW; i >= 0; i--) b[i] = (i == AW) ? g[i] : (b[i + 1] ^ g[i]);
    g2b = b;
  endfunction : g2b

  // ----------------------------------------------------------------------------
  // Receive side: address swap and frame commit.
  // ----------------------------------------------------------------------------
  mcl_pkg::mcl_beat_t mem_r [`MCL_FIFO_DEPTH];
  mcl_pkg::mcl_beat_t rx_beat, pend_r, pend_nxt, wbeat;
  logic              pend_v_r, pend_v_nxt, pend_bad_r, pend_bad_nxt, drop_r, drop_nxt;
  logic [1:0]        idx_r, idx_nxt;
  logic [AW:0]       wr_ptr_r, wr_ptr_nxt, commit_r, commit_nxt, commit_g_r;
  logic [AW:0]       rg_s1_r, rg_s2_r, cg_s1_r, cg_s2_r;
  logic [AW:0]       rd_ptr_r, rd_ptr_nxt, rd_g_r;
  logic              we, full, store, swap_now;

  assign rx_beat = '{data: rx_tdata_in, keep: rx_tkeep_in, last: rx_tlast_in};

  // Words are written one beat late so word 0 can take the source address from word 1.
  always_comb
  begin
    full       = ((wr_ptr_r - g2b(rg_s2_r)) == `MCL_FIFO_DEPTH);
    we         = pend_v_r && (rx_tvalid_in || pend_r.last);
    swap_now   = rx_tvalid_in && (idx_r == 2'h1) && !pend_r.last;
    wbeat      = pend_r;
    if (swap_now) wbeat.data = {pend_r.data[15:0], rx_tdata_in[31:0], pend_r.data[63:48]};
    store      = we && !full && !drop_r && !(pend_r.last && pend_bad_r);
    pend_nxt   = pend_r;
    pend_v_nxt = pend_v_r;
    pend_bad_nxt = pend_bad_r;
    idx_nxt    = idx_r;
    drop_nxt   = drop_r;
    wr_ptr_nxt = wr_ptr_r + {{AW{1'b0}}, store};
    commit_nxt = commit_r;
    if (we)
    begin
      pend_v_nxt = 1'b0;
      if (pend_r.last)
      begin
        drop_nxt = 1'b0;
        if (store) commit_nxt = wr_ptr_r + 1'b1;
        else       wr_ptr_nxt = commit_r;
      end
      else if (full) drop_nxt = 1'b1;
    end
    if (rx_tvalid_in)
    begin
      pend_v_nxt   = 1'b1;
      pend_nxt     = rx_beat;
      pend_bad_nxt = rx_tlast_in && !rx_tuser_in;
      if (swap_now) pend_nxt.data = {rx_tdata_in[63:32], pend_r.data[47:16]};
      idx_nxt      = rx_tlast_in ? 2'h0 : ((idx_r == 2'h2) ? 2'h2 : idx_r + 2'h1);
    end
  end

  // Registers of the receive side and the commit pointer in gray code.
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r <= '0; pend_v_r <= 1'b0; pend_bad_r <= 1'b0; drop_r <= 1'b0; idx_r <= 2'h0;
      wr_ptr_r <= '0; commit_r <= '0; commit_g_r <= '0; rg_s1_r <= '0; rg_s2_r <= '0;
    end
    else
    begin
      pend_r <= pend_nxt; pend_v_r <= pend_v_nxt; pend_bad_r <= pend_bad_nxt;
      drop_r <= drop_nxt; idx_r <= idx_nxt; wr_ptr_r <= wr_ptr_nxt; commit_r <= commit_nxt;
      commit_g_r <= b2g(commit_nxt);
      rg_s1_r <= rd_g_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  // Frame storage, written by index.
  always_ff @(posedge clk_sys_in)
  begin
    if (store) mem_r[wr_ptr_r[AW-1:0]] <= wbeat;
  end

  a_bad_no_commit: assert property (we && pend_r.last && pend_bad_r |=>
    $stable(commit_r) && wr_ptr_r == commit_r) else $error("bad frame was committed");
  a_swap_word1: assert property (swap_now |=>
    pend_r.data[31:0] == $past(pend_r.data[47:16])) else $error("address swap wrong");

  // ----------------------------------------------------------------------------
  // Transmit side: only committed frames are read.
  // ----------------------------------------------------------------------------
  mcl_pkg::mcl_beat_t tx_r, tx_nxt;
  logic               tx_v_r, tx_v_nxt, load;

  // The output beat reloads when empty or taken.
  always_comb
  begin
    load       = (rd_ptr_r != g2b(cg_s2_r)) && (!tx_v_r || tx_tready_in);
    rd_ptr_nxt = rd_ptr_r + {{AW{1'b0}}, load};
    tx_nxt     = load ? mem_r[rd_ptr_r[AW-1:0]] : tx_r;
    tx_v_nxt   = load ? 1'b1 : (tx_v_r && !tx_tready_in);
  end

  // Read pointer, its gray copy and the synchronised commit pointer.
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ptr_r <= '0; rd_g_r <= '0; tx_r <= '0; tx_v_r <= 1'b0; cg_s1_r <= '0; cg_s2_r <= '0;
    end
    else
    begin
      rd_ptr_r <= rd_ptr_nxt; rd_g_r <= b2g(rd_ptr_nxt); tx_r <= tx_nxt; tx_v_r <= tx_v_nxt;
      cg_s1_r <= commit_g_r;
      cg_s2_r <= cg_s1_r;
    end
  end

  // The MAC transmitter appends a fresh FCS over the swapped addresses.
  assign {tx_tdata_out, tx_tkeep_out, tx_tlast_out} = tx_r;
  assign tx_tvalid_out = tx_v_r;

  a_tx_hold: assert property (tx_v_r && !tx_tready_in |=> tx_v_r && $stable(tx_r))
    else $error("beat changed under back-pressure");
  a_rd_gray_step: assert property ($countones(rd_g_r ^ $past(rd_g_r)) <= 1)
    else $error("read pointer gray step too large");

  // ----------------------------------------------------------------------------
  // Management bridge.
  // ----------------------------------------------------------------------------
  mcl_pkg::mcl_br_state_t st_r, st_nxt;
  logic        awr_r, awr_nxt, wr_r, wr_nxt, arr_r, arr_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic        sel_r, sel_nxt, rnw_r, rnw_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] addr_r, addr_nxt, wd_r, wd_nxt, rd_r, rd_nxt;

  // One access at a time; select stays high until its acknowledge.
  always_comb
  begin
    st_nxt = st_r; awr_nxt = 1'b0; wr_nxt = 1'b0; arr_nxt = 1'b0; bv_nxt = bv_r; rv_nxt = rv_r;
    sel_nxt = sel_r; rnw_nxt = rnw_r; bresp_nxt = bresp_r; rresp_nxt = rresp_r;
    addr_nxt = addr_r; wd_nxt = wd_r; rd_nxt = rd_r;
    unique case (st_r)
      mcl_pkg::BR_IDLE:
        if (s_axi_awvalid_in && s_axi_wvalid_in)
        begin
          awr_nxt = 1'b1; wr_nxt = 1'b1; addr_nxt = s_axi_awaddr_in; wd_nxt = s_axi_wdata_in;
          sel_nxt = 1'b1; rnw_nxt = 1'b0; st_nxt = mcl_pkg::BR_WRITE;
        end
        else if (s_axi_arvalid_in)
        begin
          arr_nxt = 1'b1; addr_nxt = s_axi_araddr_in;
          sel_nxt = 1'b1; rnw_nxt = 1'b1; st_nxt = mcl_pkg::BR_READ;
        end
      mcl_pkg::BR_WRITE:
        if (mgmt_write_ack_in)
        begin
          sel_nxt = 1'b0; bv_nxt = 1'b1; st_nxt = mcl_pkg::BR_BRESP;
          bresp_nxt = mgmt_access_error_in ? `MCL_RESP_SLVERR : `MCL_RESP_OKAY;
        end
      mcl_pkg::BR_READ:
        if (mgmt_read_ack_in)
        begin
          sel_nxt = 1'b0; rv_nxt = 1'b1; rd_nxt = mgmt_read_word_in; st_nxt = mcl_pkg::BR_RRESP;
          rresp_nxt = mgmt_access_error_in ? `MCL_RESP_SLVERR : `MCL_RESP_OKAY;
        end
      mcl_pkg::BR_BRESP:
        if (s_axi_bready_in)
        begin
          bv_nxt = 1'b0; st_nxt = mcl_pkg::BR_IDLE;
        end
      mcl_pkg::BR_RRESP:
        if (s_axi_rready_in)
        begin
          rv_nxt = 1'b0; st_nxt = mcl_pkg::BR_IDLE;
        end
      default: st_nxt = mcl_pkg::BR_IDLE;
    endcase
  end

  // Bridge registers.
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= mcl_pkg::BR_IDLE; awr_r <= 1'b0; wr_r <= 1'b0; arr_r <= 1'b0; bv_r <= 1'b0;
      rv_r <= 1'b0; sel_r <= 1'b0; rnw_r <= 1'b0; bresp_r <= 2'h0; rresp_r <= 2'h0;
      addr_r <= 32'h0; wd_r <= 32'h0; rd_r <= 32'h0;
    end
    else
    begin
      st_r <= st_nxt; awr_r <= awr_nxt; wr_r <= wr_nxt; arr_r <= arr_nxt; bv_r <= bv_nxt;
      rv_r <= rv_nxt; sel_r <= sel_nxt; rnw_r <= rnw_nxt; bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt; addr_r <= addr_nxt; wd_r <= wd_nxt; rd_r <= rd_nxt;
    end
  end

  // Bridge outputs, all straight from registers.
  assign s_axi_awready_out = awr_r;
  assign s_axi_wready_out  = wr_r;
  assign s_axi_arready_out = arr_r;
  assign s_axi_bvalid_out  = bv_r;
  assign s_axi_bresp_out   = bresp_r;
  assign s_axi_rvalid_out  = rv_r;
  assign s_axi_rresp_out   = rresp_r;
  assign s_axi_rdata_out   = rd_r;
  assign mgmt_select_out   = sel_r;
  assign mgmt_read_not_write_out = rnw_r;
  assign mgmt_reg_address_out    = addr_r;
  assign mgmt_write_word_out     = wd_r;

  a_write_request: assert property (st_r == mcl_pkg::BR_IDLE && s_axi_awvalid_in &&
    s_axi_wvalid_in |=> mgmt_select_out && !mgmt_read_not_write_out &&
    mgmt_write_word_out == $past(s_axi_wdata_in)) else $error("write request wrong");
  a_read_request: assert property (st_r == mcl_pkg::BR_IDLE && s_axi_arvalid_in &&
    !(s_axi_awvalid_in && s_axi_wvalid_in) |=> mgmt_select_out && mgmt_read_not_write_out)
    else $error("read request wrong");
  a_select_held: assert property (mgmt_select_out && !mgmt_read_ack_in &&
    !mgmt_write_ack_in |=> mgmt_select_out && $stable(mgmt_reg_address_out))
    else $error("select dropped before acknowledge");
  a_write_error: assert property (st_r == mcl_pkg::BR_WRITE && mgmt_write_ack_in &&
    mgmt_access_error_in |=> s_axi_bvalid_out && s_axi_bresp_out == `MCL_RESP_SLVERR)
    else $error("error response missing");
  a_read_data: assert property (st_r == mcl_pkg::BR_READ && mgmt_read_ack_in |=>
    s_axi_rvalid_out && !mgmt_select_out && s_axi_rdata_out == $past(mgmt_read_word_in))
    else $error("read data not returned");

  // ----------------------------------------------------------------------------
  // PHY-side wrapper: SDR registers and DDR lanes.
  // ----------------------------------------------------------------------------
  mcl_pkg::mcl_xgmii_t sdr_tx_r, sdr_rx_r, mac_rx_r;
  logic [35:0]         rise_tx_r, hi_tx_r, fall_tx_r, rise_rx_r, fall_rx_r;

  // Rising-edge registers; the upper half waits for the falling edge.
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sdr_tx_r <= '0; sdr_rx_r <= '0; mac_rx_r <= '0; rise_tx_r <= '0; hi_tx_r <= '0;
      rise_rx_r <= '0;
    end
    else
    begin
      sdr_tx_r  <= '{d: mac_txd_in, c: mac_txc_in};
      sdr_rx_r  <= '{d: sdr_rxd_in, c: sdr_rxc_in};
      rise_tx_r <= {mac_txc_in[3:0], mac_txd_in[31:0]};
      hi_tx_r   <= {mac_txc_in[7:4], mac_txd_in[63:32]};
      rise_rx_r <= ddr_rx_in;
      mac_rx_r  <= phy_ddr_mode_in ?
        '{d: {fall_rx_r[31:0], rise_rx_r[31:0]}, c: {fall_rx_r[35:32], rise_rx_r[35:32]}} :
        sdr_rx_r;
    end
  end

  // Falling-edge halves of the DDR lanes.
  always_ff @(negedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fall_tx_r <= '0; fall_rx_r <= '0;
    end
    else
    begin
      fall_tx_r <= hi_tx_r;
      fall_rx_r <= ddr_rx_in;
    end
  end

  assign {sdr_txd_out, sdr_txc_out} = sdr_tx_r;
  assign {mac_rxd_out, mac_rxc_out} = mac_rx_r;
  assign ddr_tx_rise_out = rise_tx_r;
  assign ddr_tx_fall_out = fall_tx_r;

  a_sdr_tx_reg: assert property (##1 sdr_txd_out == $past(mac_txd_in))
    else $error("SDR transmit not registered");
endmodule : mcl_top

// ---- mcl_mgmt_model.sv ----
/*
  Behavioural model of the MAC register port that answers the management bridge.
  Assumes the bridge holds select until the acknowledge and runs on the system clock.
*/
`timescale 1ns/1ps
module mcl_mgmt_model (
  input  wire logic        clk_in,        // System clock.
  input  wire logic        nrst_in,       // Reset, active low.
  input  wire logic [3:0]  wait_in,       // Cycles of select before the answer.
  input  wire logic        select_in,     // Register port select.
  input  wire logic        rnw_in,        // High for read, low for write.
  input  wire logic [31:0] addr_in,       // Register address.
  output logic      [31:0] read_word_out, // Read word, only valid with the read ack.
  output logic             read_ack_out,  // Read acknowledge pulse.
  output logic             write_ack_out, // Write acknowledge pulse.
  output logic             error_out      // Access error, only valid with an ack.
);
  logic [3:0] cnt_r;
  logic       done_r;
  // One answer per select; address bit 31 marks an invalid register.
  // Outside the answer the word and error wander so stale values are never trusted.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt_r         <= 4'h0;
      done_r        <= 1'b0;
      read_word_out <= 32'h0;
      read_ack_out  <= 1'b0;
      write_ack_out <= 1'b0;
      error_out     <= 1'b0;
    end
    else
    begin
      read_ack_out  <= 1'b0;
      write_ack_out <= 1'b0;
      error_out     <= ~error_out;
      read_word_out <= ~read_word_out;
      if (!select_in)
      begin
        cnt_r  <= 4'h0;
        done_r <= 1'b0;
      end
      else if (!done_r && cnt_r == wait_in)
      begin
        done_r        <= 1'b1;
        read_ack_out  <= rnw_in;
        write_ack_out <= !rnw_in;
        error_out     <= addr_in[31];
        read_word_out <= addr_in ^ 32'h5a5a0000;
      end
      else if (!done_r)
      begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule : mcl_mgmt_model

// ---- testbench.sv ----
/*
  Self-checking bench for the client loopback, management bridge and PHY registers.
  Assumes mcl_top and mcl_mgmt_model are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic clk_sys, nrst, rx_tvalid, rx_tlast, rx_tuser, tx_tvalid, tx_tlast, tx_tready;
  logic [63:0] rx_tdata, tx_tdata, mac_txd, mac_rxd, sdr_txd, sdr_rxd;
  logic [7:0]  rx_tkeep, tx_tkeep, mac_txc, mac_rxc, sdr_txc, sdr_rxc;
  logic [31:0] awaddr, wdata, araddr, rdata, m_addr, m_wword, m_rword;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic        m_sel, m_rnw, m_rack, m_wack, m_err;
  logic [35:0] ddr_rise, ddr_fall, ddr_rx;
  logic        ddr_mode;
  logic [3:0]  m_wait;
  mcl_pkg::mcl_beat_t out_q[$];
  mcl_pkg::mcl_beat_t exp_b[4];
  int failures, tests_run, cycles;
  mcl_top DUT (.clk_sys_in(clk_sys), .nrst_in(nrst), .rx_tdata_in(rx_tdata),
    .rx_tkeep_in(rx_tkeep), .rx_tvalid_in(rx_tvalid), .rx_tlast_in(rx_tlast),
    .rx_tuser_in(rx_tuser), .tx_tdata_out(tx_tdata), .tx_tkeep_out(tx_tkeep),
    .tx_tvalid_out(tx_tvalid), .tx_tlast_out(tx_tlast), .tx_tready_in(tx_tready),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .mgmt_select_out(m_sel), .mgmt_read_not_write_out(m_rnw),
    .mgmt_reg_address_out(m_addr), .mgmt_write_word_out(m_wword),
    .mgmt_read_word_in(m_rword), .mgmt_read_ack_in(m_rack), .mgmt_write_ack_in(m_wack),
    .mgmt_access_error_in(m_err), .phy_ddr_mode_in(ddr_mode), .mac_txd_in(mac_txd),
    .mac_txc_in(mac_txc), .mac_rxd_out(mac_rxd), .mac_rxc_out(mac_rxc),
    .sdr_txd_out(sdr_txd), .sdr_txc_out(sdr_txc), .sdr_rxd_in(sdr_rxd),
    .sdr_rxc_in(sdr_rxc), .ddr_tx_rise_out(ddr_rise), .ddr_tx_fall_out(ddr_fall),
    .ddr_rx_in(ddr_rx));
  mcl_mgmt_model u_mgmt (.clk_in(clk_sys), .nrst_in(nrst), .wait_in(m_wait),
    .select_in(m_sel), .rnw_in(m_rnw), .addr_in(m_addr), .read_word_out(m_rword),
    .read_ack_out(m_rack), .write_ack_out(m_wack), .error_out(m_err));
  // Clock, cycle ceiling and capture of every accepted looped beat.
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (tx_tvalid === 1'b1 && tx_tready === 1'b1)
      out_q.push_back('{data: tx_tdata, keep: tx_tkeep, last: tx_tlast});
    if (cycles == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Waits up to 50 edges for a flag, sampling once each edge has settled.
  task automatic wait_flag(ref logic f);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (f !== 1'b1 && n < 50);
  endtask : wait_flag
  // Full AXI write; the request is held until the edge that samples the ready pulse.
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(negedge clk_sys);
    awaddr = a; wdata = d; awvalid = 1'b1; wvalid = 1'b1; bready = 1'b1;
    wait_flag(awready);
    `CHK("wready", 1'b1, wready)
    `CHK("write select", 1'b1, m_sel)
    `CHK("write rnw", 1'b0, m_rnw)
    `CHK("write address", a, m_addr)
    `CHK("write word", d, m_wword)
    @(posedge clk_sys);
    @(negedge clk_sys);
    awvalid = 1'b0; wvalid = 1'b0;
    wait_flag(bvalid);
    `CHK("bresp", r, bresp)
    @(posedge clk_sys);
    @(negedge clk_sys);
    bready = 1'b0;
  endtask : axi_write
  // Full AXI read, the returned word is the model's answer for that address.
  task automatic axi_read(input logic [31:0] a, input logic [1:0] r);
    @(negedge clk_sys);
    araddr = a; arvalid = 1'b1; rready = 1'b1;
    wait_flag(arready);
    `CHK("read select", 1'b1, m_sel)
    `CHK("read rnw", 1'b1, m_rnw)
    `CHK("read address", a, m_addr)
    @(posedge clk_sys);
    @(negedge clk_sys);
    arvalid = 1'b0;
    wait_flag(rvalid);
    `CHK("rresp", r, rresp)
    if (r == `MCL_RESP_OKAY)
      `CHK("rdata", a ^ 32'h5a5a0000, rdata)
    @(posedge clk_sys);
    @(negedge clk_sys);
    rready = 1'b0;
  endtask : axi_read
  task automatic send_beat(input logic [63:0] d, input logic [7:0] k, input logic l,
                           input logic u);
    rx_tdata = d; rx_tkeep = k; rx_tlast = l; rx_tuser = u; rx_tvalid = 1'b1;
    @(negedge clk_sys);
  endtask : send_beat
  // Bad frame, then a good three-beat and one-beat frame back to back, with stall.
  task automatic test_loopback;
    @(negedge clk_sys);
    out_q.delete();
    send_beat(64'hdeaddeaddeaddead, 8'hff, 1'b0, 1'b0);
    send_beat(64'hbeefbeefbeefbeef, 8'h0f, 1'b1, 1'b0);
    send_beat(64'h0706050403020100, 8'hff, 1'b0, 1'b0);
    send_beat(64'h0f0e0d0c0b0a0908, 8'hff, 1'b0, 1'b0);
    send_beat(64'h1716151413121110, 8'h0f, 1'b1, 1'b1);
    send_beat(64'h1122334455667788, 8'hff, 1'b1, 1'b1);
    rx_tvalid = 1'b0;
    tx_tready = 1'b0;
    repeat (12) @(negedge clk_sys);
    tx_tready = 1'b1;
    repeat (30) @(negedge clk_sys);
    exp_b[0] = '{data: 64'h01000b0a09080706, keep: 8'hff, last: 1'b0};
    exp_b[1] = '{data: 64'h0f0e0d0c05040302, keep: 8'hff, last: 1'b0};
    exp_b[2] = '{data: 64'h1716151413121110, keep: 8'h0f, last: 1'b1};
    exp_b[3] = '{data: 64'h1122334455667788, keep: 8'hff, last: 1'b1};
    `CHK("looped beat count", 32'd4, 32'(out_q.size()))
    if (out_q.size() == 4)
      for (int i = 0; i < 4; i++)
        `CHK("looped beat", exp_b[i], out_q[i])
  endtask : test_loopback
  // PHY-side registers: SDR words both ways and the DDR transmit halves.
  task automatic test_phy;
    @(negedge clk_sys);
    mac_txd = 64'h0123456789abcdef; mac_txc = 8'ha5;
    sdr_rxd = 64'hfedcba9876543210; sdr_rxc = 8'h3c;
    @(posedge clk_sys);
    #1;
    `CHK("sdr txd", mac_txd, sdr_txd)
    `CHK("sdr txc", mac_txc, sdr_txc)
    `CHK("ddr rise", {mac_txc[3:0], mac_txd[31:0]}, ddr_rise)
    @(negedge clk_sys);
    #1;
    `CHK("ddr fall", {mac_txc[7:4], mac_txd[63:32]}, ddr_fall)
    // The receive word passes an input register and the output register.
    @(posedge clk_sys);
    #1;
    `CHK("mac rxd", sdr_rxd, mac_rxd)
    `CHK("mac rxc", sdr_rxc, mac_rxc)
    // DDR receive path: the same lanes on both edges fill both halves.
    @(negedge clk_sys);
    ddr_mode = 1'b1; ddr_rx = 36'ha12345678;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("ddr rxd", {2{ddr_rx[31:0]}}, mac_rxd)
    `CHK("ddr rxc", {2{ddr_rx[35:32]}}, mac_rxc)
    @(negedge clk_sys);
    ddr_mode = 1'b0;
  endtask : test_phy
  // Reset for eight cycles, then the scenarios in turn.
  initial
  begin
    failures = 0; tests_run = 0; cycles = 0; nrst = 1'b0; m_wait = 4'h0;
    rx_tdata = 64'h0; rx_tkeep = 8'h0; rx_tvalid = 1'b0; rx_tlast = 1'b0; rx_tuser = 1'b0;
    tx_tready = 1'b1; awaddr = 32'h0; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0;
    bready = 1'b0; araddr = 32'h0; arvalid = 1'b0; rready = 1'b0;
    mac_txd = 64'h0; mac_txc = 8'h0; sdr_rxd = 64'h0; sdr_rxc = 8'h0;
    ddr_mode = 1'b0; ddr_rx = 36'h0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(posedge clk_sys);
    test_phy();
    axi_write(32'h00000404, 32'hcafe1234, `MCL_RESP_OKAY);
    m_wait = 4'h5;
    axi_write(32'h80000010, 32'h0badf00d, `MCL_RESP_SLVERR);
    m_wait = 4'h3;
    axi_read(32'h00000408, `MCL_RESP_OKAY);
    m_wait = 4'h0;
    axi_read(32'h80000020, `MCL_RESP_SLVERR);
    test_loopback();
    print_verdict();
  end
endmodule : testbench
